// ### shared/hmcdaf_pkg.sv
// ----------------------------------------------------------------
// host mac indirect csr window and automatic flow control
// ----------------------------------------------------------------
package hmcdaf_pkg;

	// ------------------------------------------------------------
	// clock and bus
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int APB_AW = 12;

	// register byte addresses
	localparam logic [11:0] ADDR_CMD = 12'h0a4;
	localparam logic [11:0] ADDR_DATA = 12'h0a8;
	localparam logic [11:0] ADDR_AFC = 12'h0ac;
	localparam logic [11:0] ADDR_STAT = 12'h0b0;

	// reset values and writable masks
	localparam logic [31:0] RST_CMD = 32'h00000000;
	localparam logic [31:0] RST_DATA = 32'h00000000;
	localparam logic [31:0] RST_AFC = 32'h00000000;
	localparam logic [31:0] AFC_WMASK = 32'h00ffffff;

	// command register fields
	localparam int CMD_BUSY_BIT = 31;
	localparam int CMD_RDSEL_BIT = 30;
	localparam int CMD_ADDR_W = 8;
	localparam int CMD_RSVD_W = 22;

	// fifo level granularity: 64-byte units
	localparam int LEVEL_SHIFT = 6;
	localparam int LEVEL_W = 16 - LEVEL_SHIFT;

	// ------------------------------------------------------------
	// backpressure duration timing
	// ------------------------------------------------------------
	localparam int TICK_NS = 200;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int BP_T0_NS = 5000;
	localparam int BP_T1_NS = 10000;
	localparam int BP_T2_NS = 15000;
	localparam int BP_T3_NS = 25000;
	localparam int BP_T4_NS = 50000;
	localparam int BP_T5_NS = 100000;
	localparam int BP_STEP_NS = 50000;
	localparam int BP_STEP_BASE = 5;
	localparam int BP_SLOW_EXTRA_NS = 2200;
	localparam int BP_TICK_W = 12;

	// duration code to hold time in ticks, longer at 10 Mb/s
	function automatic logic [11:0] bp_ticks(input logic [3:0] code,
		input logic fast);
		int ns;
		ns = 0;
		case (code)
			4'h0: ns = BP_T0_NS;
			4'h1: ns = BP_T1_NS;
			4'h2: ns = BP_T2_NS;
			4'h3: ns = BP_T3_NS;
			4'h4: ns = BP_T4_NS;
			default: ns = BP_T5_NS + BP_STEP_NS * (int'(code) - BP_STEP_BASE);
		endcase
		if (!fast) begin
			ns = ns + BP_SLOW_EXTRA_NS;
		end
		return 12'(ns / TICK_NS);
	endfunction

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} hmcdaf_csr_req_t;

	typedef struct packed {
		logic start;
		logic multicast;
		logic broadcast;
		logic ownAddr;
	} hmcdaf_rx_frame_t;

	typedef struct packed {
		logic txEnabled;
		logic fullDuplex;
		logic speed100;
		logic hwFcEnable;
	} hmcdaf_mac_mode_t;

	typedef struct packed {
		logic [7:0] rsvd;
		logic [7:0] hi;
		logic [7:0] lo;
		logic [3:0] dur;
		logic multEn;
		logic brdEn;
		logic ownEn;
		logic anyEn;
	} hmcdaf_auto_flow_control_config_t;

	typedef struct packed {
		logic [5:0] rsvdHi;
		logic [9:0] level;
		logic [11:0] rsvdLo;
		logic pausePending;
		logic hwFcActive;
		logic bpActive;
		logic pauseSent;
	} hmcdaf_status_t;

	typedef enum logic {BR_IDLE, BR_WAIT} hmcdaf_bridge_state_t;
	typedef enum logic {PS_IDLE, PS_PEND} hmcdaf_pause_state_t;

endpackage

// ### core/hmcdaf_csr_bridge.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// indirect access engine toward the internal mac registers
// ----------------------------------------------------------------
module hmcdaf_csr_bridge (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic cmdWr,
	input wire logic dataWr,
	input wire logic [31:0] wdata,
	output logic [31:0] cmdValue,
	output logic [31:0] dataValue,
	output logic busy,
	output hmcdaf_pkg::hmcdaf_csr_req_t csrReq,
	input wire logic csrAck,
	input wire logic [31:0] csrRdata
);

	hmcdaf_pkg::hmcdaf_bridge_state_t state_r, state_nxt;
	logic rdSel_r, rdSel_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [31:0] written_r, written_nxt;
	logic [31:0] fetched_r, fetched_nxt;

	// next state: a set busy bit launches, ack retires
	always_comb begin
		state_nxt = state_r;
		rdSel_nxt = rdSel_r;
		addr_nxt = addr_r;
		written_nxt = written_r;
		fetched_nxt = fetched_r;
		case (state_r)
			hmcdaf_pkg::BR_IDLE: begin
				if (cmdWr) begin
					rdSel_nxt = wdata[hmcdaf_pkg::CMD_RDSEL_BIT];
					addr_nxt = wdata[7:0];
					if (wdata[hmcdaf_pkg::CMD_BUSY_BIT]) begin
						state_nxt = hmcdaf_pkg::BR_WAIT;
					end
				end
				if (dataWr) begin
					written_nxt = wdata;
				end
			end
			hmcdaf_pkg::BR_WAIT: begin
				// busy holds until the internal access acks
				if (csrAck) begin
					if (rdSel_r) begin
						fetched_nxt = csrRdata;
					end
					state_nxt = hmcdaf_pkg::BR_IDLE;
				end
			end
			default: state_nxt = hmcdaf_pkg::BR_IDLE;
		endcase
	end

	// registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_r <= hmcdaf_pkg::BR_IDLE;
			rdSel_r <= 1'b0;
			addr_r <= 8'h00;
			written_r <= hmcdaf_pkg::RST_DATA;
			fetched_r <= hmcdaf_pkg::RST_DATA;
		end else begin
			state_r <= state_nxt;
			rdSel_r <= rdSel_nxt;
			addr_r <= addr_nxt;
			written_r <= written_nxt;
			fetched_r <= fetched_nxt;
		end
	end

	// outputs, all straight from flops
	assign busy = (state_r == hmcdaf_pkg::BR_WAIT);
	assign cmdValue = {busy, rdSel_r, {hmcdaf_pkg::CMD_RSVD_W{1'b0}}, addr_r};
	assign dataValue = rdSel_r ? fetched_r : written_r;
	assign csrReq.valid = busy;
	assign csrReq.write = ~rdSel_r;
	assign csrReq.addr = addr_r;
	assign csrReq.wdata = written_r;

endmodule

// ### core/hmcdaf_bp_timer.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// backpressure hold timer, counts in coarse ticks
// ----------------------------------------------------------------
module hmcdaf_bp_timer (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [3:0] code,
	input wire logic fast,
	output logic active
);

	localparam int PRE_W = $clog2(hmcdaf_pkg::TICK_CYCLES);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(hmcdaf_pkg::TICK_CYCLES - 1);

	logic [PRE_W-1:0] pre_r, pre_nxt;
	logic [11:0] remain_r, remain_nxt;
	logic tick;

	// prescaler keeps every count well under the long-count limit
	assign tick = (pre_r == PRE_LAST);

	// a new matching frame reloads the whole period
	always_comb begin
		pre_nxt = tick ? '0 : PRE_W'(pre_r + 1'b1);
		remain_nxt = remain_r;
		if (start) begin
			pre_nxt = '0;
			remain_nxt = hmcdaf_pkg::bp_ticks(code, fast);
		end else if (tick && remain_r != 12'h000) begin
			remain_nxt = 12'(remain_r - 1'b1);
		end
	end

	// registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pre_r <= '0;
			remain_r <= 12'h000;
		end else begin
			pre_r <= pre_nxt;
			remain_r <= remain_nxt;
		end
	end

	assign active = (remain_r != 12'h000);

endmodule

// ### core/hmcdaf_top.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module hmcdaf_top (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire hmcdaf_pkg::hmcdaf_mac_mode_t macMode,
	input wire logic [15:0] rxDataUsed,
	input wire hmcdaf_pkg::hmcdaf_rx_frame_t rxFrame,
	input wire logic [15:0] pauseTimeField,
	output hmcdaf_pkg::hmcdaf_csr_req_t csrReq,
	input wire logic csrAck,
	input wire logic [31:0] csrRdata,
	output logic pauseReq,
	output logic [15:0] pauseTime,
	input wire logic pauseAck,
	output logic jamActive,
	output logic hwFcAssert
);

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	logic setupPhase;
	logic accessPhase;
	logic hitCmd;
	logic hitData;
	logic hitAfc;
	logic hitStat;
	logic mapped;
	logic wrAccess;
	logic bridgeBusy;
	logic cmdWr;
	logic dataWr;
	logic [31:0] cmdValue;
	logic [31:0] dataValue;

	// address match on the whole aligned word
	assign setupPhase = psel & ~penable;
	assign accessPhase = psel & penable;
	assign hitCmd = (paddr == hmcdaf_pkg::ADDR_CMD);
	assign hitData = (paddr == hmcdaf_pkg::ADDR_DATA);
	assign hitAfc = (paddr == hmcdaf_pkg::ADDR_AFC);
	assign hitStat = (paddr == hmcdaf_pkg::ADDR_STAT);
	assign mapped = hitCmd | hitData | hitAfc | hitStat;
	assign wrAccess = accessPhase & pwrite & mapped;

	// the slave never stalls; unmapped words answer with an error
	assign pready = 1'b1;
	assign pslverr = accessPhase & ~mapped;

	// writes to the window while busy are dropped, not queued
	assign cmdWr = wrAccess & hitCmd & ~bridgeBusy;
	assign dataWr = wrAccess & hitData & ~bridgeBusy;

	// ------------------------------------------------------------
	// indirect window
	// ------------------------------------------------------------
	hmcdaf_csr_bridge u_bridge (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.cmdWr(cmdWr),
		.dataWr(dataWr),
		.wdata(pwdata),
		.cmdValue(cmdValue),
		.dataValue(dataValue),
		.busy(bridgeBusy),
		.csrReq(csrReq),
		.csrAck(csrAck),
		.csrRdata(csrRdata)
	);

	// ------------------------------------------------------------
	// flow control configuration register
	// ------------------------------------------------------------
	logic [31:0] afc_r, afc_nxt;
	hmcdaf_pkg::hmcdaf_auto_flow_control_config_t cfg;

	// reserved top byte is never stored, so it reads zero
	always_comb begin
		afc_nxt = afc_r;
		if (wrAccess && hitAfc) begin
			afc_nxt = pwdata & hmcdaf_pkg::AFC_WMASK;
		end
	end

	// register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			afc_r <= hmcdaf_pkg::RST_AFC;
		end else begin
			afc_r <= afc_nxt;
		end
	end

	assign cfg = hmcdaf_pkg::hmcdaf_auto_flow_control_config_t'(afc_r);

	// ------------------------------------------------------------
	// fifo level compare
	// ------------------------------------------------------------
	logic [hmcdaf_pkg::LEVEL_W-1:0] fifoLevel;
	logic reachedHi;
	logic belowLo;
	logic autoEn;
	logic txOn;
	logic fdMode;

	// byte count down to 64-byte units, no rounding up
	assign fifoLevel = rxDataUsed[15:hmcdaf_pkg::LEVEL_SHIFT];
	assign reachedHi = fifoLevel >= {2'b00, cfg.hi};
	assign belowLo = fifoLevel < {2'b00, cfg.lo};
	assign autoEn = cfg.anyEn | cfg.ownEn | cfg.brdEn | cfg.multEn;
	assign txOn = macMode.txEnabled;
	assign fdMode = macMode.fullDuplex;

	// ------------------------------------------------------------
	// full duplex pause generation
	// ------------------------------------------------------------
	hmcdaf_pkg::hmcdaf_pause_state_t pState_r, pState_nxt;
	logic pauseSent_r, pauseSent_nxt;
	logic [15:0] pauseTime_r, pauseTime_nxt;
	logic fdPauseEn;
	logic resumeEn;

	// only any-frame turns on full duplex pause
	assign fdPauseEn = cfg.anyEn & fdMode & txOn;
	assign resumeEn = autoEn & fdMode & txOn;

	// one request outstanding at a time; the flag blocks repeats
	always_comb begin
		pState_nxt = pState_r;
		pauseSent_nxt = pauseSent_r;
		pauseTime_nxt = pauseTime_r;
		case (pState_r)
			hmcdaf_pkg::PS_IDLE: begin
				if (fdPauseEn && reachedHi && !pauseSent_r) begin
					pauseTime_nxt = pauseTimeField;
					pauseSent_nxt = 1'b1;
					pState_nxt = hmcdaf_pkg::PS_PEND;
				end else if (resumeEn && pauseSent_r && belowLo) begin
					pauseTime_nxt = 16'h0000;
					pauseSent_nxt = 1'b0;
					pState_nxt = hmcdaf_pkg::PS_PEND;
				end
			end
			hmcdaf_pkg::PS_PEND: begin
				// a disabled transmitter withdraws the request
				if (pauseAck || !txOn) begin
					pState_nxt = hmcdaf_pkg::PS_IDLE;
				end
			end
			default: pState_nxt = hmcdaf_pkg::PS_IDLE;
		endcase
	end

	// registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pState_r <= hmcdaf_pkg::PS_IDLE;
			pauseSent_r <= 1'b0;
			pauseTime_r <= 16'h0000;
		end else begin
			pState_r <= pState_nxt;
			pauseSent_r <= pauseSent_nxt;
			pauseTime_r <= pauseTime_nxt;
		end
	end

	// request lives only toward the host mac transmitter
	assign pauseReq = (pState_r == hmcdaf_pkg::PS_PEND) & txOn;
	assign pauseTime = pauseTime_r;

	// ------------------------------------------------------------
	// half duplex backpressure
	// ------------------------------------------------------------
	logic frameMatch;
	logic bpStart;
	logic bpActive;

	// any-frame jams on every preamble, skipping address decode
	assign frameMatch = cfg.anyEn |
		(rxFrame.multicast & cfg.multEn) |
		(rxFrame.broadcast & cfg.brdEn) |
		(rxFrame.ownAddr & cfg.ownEn);

	// every matching frame past the high level restarts the hold
	assign bpStart = rxFrame.start & frameMatch & ~fdMode & txOn &
		reachedHi;

	hmcdaf_bp_timer u_bpTimer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(bpStart),
		.code(cfg.dur),
		.fast(macMode.speed100),
		.active(bpActive)
	);

	// duration never applies in full duplex
	assign jamActive = bpActive & ~fdMode & txOn;

	// ------------------------------------------------------------
	// hardwired flow control hysteresis
	// ------------------------------------------------------------
	logic hwFc_r, hwFc_nxt;

	// asserts at high, releases below low, idle when disabled
	always_comb begin
		hwFc_nxt = hwFc_r;
		if (!macMode.hwFcEnable) begin
			hwFc_nxt = 1'b0;
		end else if (reachedHi) begin
			hwFc_nxt = 1'b1;
		end else if (belowLo) begin
			hwFc_nxt = 1'b0;
		end
	end

	// register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			hwFc_r <= 1'b0;
		end else begin
			hwFc_r <= hwFc_nxt;
		end
	end

	assign hwFcAssert = hwFc_r & txOn;

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	hmcdaf_pkg::hmcdaf_status_t status;
	logic [31:0] prdata_r, prdata_nxt;

	// status word
	always_comb begin
		status = '0;
		status.level = fifoLevel;
		status.pausePending = (pState_r == hmcdaf_pkg::PS_PEND);
		status.hwFcActive = hwFc_r;
		status.bpActive = bpActive;
		status.pauseSent = pauseSent_r;
	end

	// sampled in the setup phase so the access phase sees a flop
	always_comb begin
		prdata_nxt = prdata_r;
		if (setupPhase && !pwrite) begin
			prdata_nxt = 32'h00000000;
			if (hitCmd) begin
				prdata_nxt = cmdValue;
			end else if (hitData) begin
				prdata_nxt = dataValue;
			end else if (hitAfc) begin
				prdata_nxt = afc_r;
			end else if (hitStat) begin
				prdata_nxt = status;
			end
		end
	end

	// register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prdata_r <= 32'h00000000;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata = prdata_r;

endmodule

// ### tb/hmcdaf_top_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checks for the csr window and flow control
// ----------------------------------------------------------------
module hmcdaf_top_asserts (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire hmcdaf_pkg::hmcdaf_mac_mode_t macMode,
	input wire logic [15:0] rxDataUsed,
	input wire hmcdaf_pkg::hmcdaf_rx_frame_t rxFrame,
	input wire hmcdaf_pkg::hmcdaf_csr_req_t csrReq,
	input wire logic csrAck,
	input wire logic pauseReq,
	input wire logic [15:0] pauseTime,
	input wire logic pauseAck,
	input wire logic jamActive,
	input wire logic hwFcAssert
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	hmcdaf_pkg::hmcdaf_auto_flow_control_config_t cfg_r;
	hmcdaf_pkg::hmcdaf_auto_flow_control_config_t cfg_nxt;
	logic [9:0] lvl;
	logic mapped;
	logic match;
	// shadow of the flow config, since its flops are out of sight
	always_comb begin
		cfg_nxt = cfg_r;
		if (psel && penable && pwrite && paddr == hmcdaf_pkg::ADDR_AFC) begin
			cfg_nxt = hmcdaf_pkg::hmcdaf_auto_flow_control_config_t'(pwdata);
		end
		lvl = rxDataUsed[15:6];
		mapped = paddr inside {hmcdaf_pkg::ADDR_CMD, hmcdaf_pkg::ADDR_DATA,
			hmcdaf_pkg::ADDR_AFC, hmcdaf_pkg::ADDR_STAT};
		match = cfg_r.anyEn || (cfg_r.multEn && rxFrame.multicast) ||
			(cfg_r.brdEn && rxFrame.broadcast) || (cfg_r.ownEn && rxFrame.ownAddr);
	end
	always_ff @(posedge core_clk) begin
		cfg_r <= sys_rst ? hmcdaf_pkg::hmcdaf_auto_flow_control_config_t'(32'h0) : cfg_nxt;
	end

	a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
		else $error("unmapped access without error");
	a_tx_off_quiet: assert property (
		!macMode.txEnabled |-> !pauseReq && !jamActive && !hwFcAssert)
		else $error("flow control active with transmitter off");
	a_req_held: assert property (
		csrReq.valid && !csrAck |=> csrReq.valid && $stable(csrReq))
		else $error("indirect request changed before ack");
	a_req_done: assert property (
		csrReq.valid && csrAck |=> !csrReq.valid)
		else $error("indirect request still up after ack");
	a_pause_hold: assert property (
		pauseReq && !pauseAck |=>
		!macMode.txEnabled || (pauseReq && $stable(pauseTime)))
		else $error("pause request lost or changed before ack");
	a_pause_once: assert property (pauseReq && pauseAck |=> !pauseReq)
		else $error("pause request held after ack");
	a_jam_fd_off: assert property (macMode.fullDuplex |-> !jamActive)
		else $error("backpressure in full duplex");
	a_jam_trigger: assert property (
		rxFrame.start && match && !macMode.fullDuplex &&
		macMode.txEnabled && lvl >= 10'(cfg_r.hi) |=>
		jamActive || !macMode.txEnabled || macMode.fullDuplex)
		else $error("matching frame over high level not jammed");
	a_hwfc_set: assert property (
		macMode.hwFcEnable && lvl >= 10'(cfg_r.hi) |=>
		hwFcAssert || !macMode.txEnabled)
		else $error("hardwired flow control not raised");
	a_hwfc_clear: assert property (
		!macMode.hwFcEnable || lvl < 10'(cfg_r.lo) |=> !hwFcAssert)
		else $error("hardwired flow control not dropped");
endmodule

bind hmcdaf_top hmcdaf_top_asserts u_chk (.core_clk(core_clk),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .macMode(macMode),
	.rxDataUsed(rxDataUsed), .rxFrame(rxFrame), .csrReq(csrReq),
	.csrAck(csrAck), .pauseReq(pauseReq), .pauseTime(pauseTime),
	.pauseAck(pauseAck), .jamActive(jamActive), .hwFcAssert(hwFcAssert));

// ### tb/hmcdaf_mac_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// internal mac register file and pause frame sender
// ----------------------------------------------------------------
module hmcdaf_mac_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [3:0] lat,
	input wire hmcdaf_pkg::hmcdaf_csr_req_t csrReq,
	output logic csrAck,
	output logic [31:0] csrRdata,
	input wire logic pauseReq,
	output logic pauseAck
);
	logic [31:0] mem [256];
	logic [3:0] waitCnt_r;
	// one shared wait, so csr and pause answers never coincide
	always @(posedge core_clk) begin
		csrAck <= 1'b0;
		pauseAck <= 1'b0;
		csrRdata <= ~csrRdata; // stale data never looks valid
		waitCnt_r <= waitCnt_r + 4'h1;
		if (sys_rst || !(csrReq.valid || pauseReq) || csrAck || pauseAck) begin
			waitCnt_r <= 4'h0;
			if (sys_rst) begin
				csrRdata <= 32'h0;
			end
		end else if (waitCnt_r >= lat) begin
			if (csrReq.valid) begin
				csrAck <= 1'b1;
				if (csrReq.write) begin
					mem[csrReq.addr] <= csrReq.wdata;
				end else begin
					csrRdata <= mem[csrReq.addr];
				end
			end else begin
				pauseAck <= 1'b1;
			end
		end
	end
endmodule

// ### tb/test_host_indirect_mac_register_data_and_afc.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// self-checking bench for the csr window and flow control
// ----------------------------------------------------------------
module test_host_indirect_mac_register_data_and_afc;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	hmcdaf_pkg::hmcdaf_mac_mode_t macMode = 4'h0;
	logic [15:0] rxDataUsed = 16'h0;
	hmcdaf_pkg::hmcdaf_rx_frame_t rxFrame = 4'h0;
	logic [15:0] pauseTimeField = 16'h0;
	hmcdaf_pkg::hmcdaf_csr_req_t csrReq;
	logic csrAck;
	logic [31:0] csrRdata;
	logic pauseReq;
	logic [15:0] pauseTime;
	logic pauseAck;
	logic jamActive;
	logic hwFcAssert;
	logic [3:0] lat = 4'h2;
	int errors = 0;
	int n_checks = 0;
	logic [31:0] seed = 32'hcc95;
	logic [31:0] rd;
	logic err;
	logic [31:0] shadow [4];
	logic [3:0] codes [4] = '{4'h0, 4'h4, 4'h5, 4'hf};
	// class enable per jam pass and the frame that it matches
	logic [3:0] ens [4] = '{4'h2, 4'h8, 4'h4, 4'h8};
	logic [3:0] hits [4] = '{4'h9, 4'hc, 4'ha, 4'hc};

	hmcdaf_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.macMode(macMode), .rxDataUsed(rxDataUsed), .rxFrame(rxFrame),
		.pauseTimeField(pauseTimeField), .csrReq(csrReq), .csrAck(csrAck),
		.csrRdata(csrRdata), .pauseReq(pauseReq), .pauseTime(pauseTime),
		.pauseAck(pauseAck), .jamActive(jamActive), .hwFcAssert(hwFcAssert));
	hmcdaf_mac_model peer (.core_clk(core_clk), .sys_rst(sys_rst),
		.lat(lat), .csrReq(csrReq), .csrAck(csrAck), .csrRdata(csrRdata),
		.pauseReq(pauseReq), .pauseAck(pauseAck));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected hold in cycles: 200 ns ticks of 5 clocks
	function automatic int jamLen(input int c, input logic fast);
		int ns;
		ns = c < 3 ? 5000 * (c + 1) : c == 3 ? 25000 : c == 4 ? 50000 :
			100000 + 50000 * (c - 5);
		ns = fast ? ns : ns + 2200;
		return ns / 200 * 5;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; request held until pready seen at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic quiet(input int n);
		int c;
		c = 0;
		repeat (n) begin
			@(posedge core_clk);
			c += (pauseReq !== 1'b0);
		end
		check(32'(c), 32'h0);
	endtask
	task automatic pause(input logic [15:0] t);
		for (int k = 0; k < 20 && pauseReq !== 1'b1; k++) @(posedge core_clk);
		check({15'h0, pauseReq, pauseTime}, {16'h1, t});
		for (int k = 0; k < 40 && pauseReq !== 1'b0; k++) @(posedge core_clk);
	endtask
	// one frame start pulse, then the jam length in cycles
	task automatic jam(input logic [3:0] f, input int exp);
		int c;
		c = 0;
		@(posedge core_clk);
		rxFrame <= f;
		@(posedge core_clk);
		rxFrame <= 4'h0;
		@(posedge core_clk);
		while (jamActive === 1'b1 && c < 20000) begin
			c++;
			@(posedge core_clk);
		end
		c = (c >= exp - 2 && c <= exp + 2) ? exp : c;
		check(32'(c), 32'(exp));
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		forever #20 core_clk = ~core_clk;
	end
	// watchdog sized well above the expected run
	initial begin
		repeat (80000) @(posedge core_clk);
		errors++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		apb(1'b0, hmcdaf_pkg::ADDR_DATA, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, hmcdaf_pkg::ADDR_AFC, 32'h0);
		check(rd, 32'h0);
		check({30'h0, pready, err}, 32'h2);
		apb(1'b0, 12'h0bc, 32'h0);
		check({31'h0, err}, 32'h1);
		seed = lfsr(seed);
		// enables left off, so random levels cannot break the low rule
		apb(1'b1, hmcdaf_pkg::ADDR_AFC, {seed[31:4], 4'h0});
		apb(1'b0, hmcdaf_pkg::ADDR_AFC, 32'h0);
		check(rd, {8'h00, seed[23:4], 4'h0});
		$display("test registers done");
		// four writes through the window, then reads of the same places
		for (int j = 0; j < 8; j++) begin
			seed = lfsr(seed);
			lat <= seed[3:0];
			apb(1'b1, hmcdaf_pkg::ADDR_DATA, seed);
			apb(1'b1, hmcdaf_pkg::ADDR_CMD, {1'b1, j[2], 22'h0, 8'(j % 4)});
			rd = 32'h80000000;
			for (int k = 0; k < 40 && rd[31]; k++) begin
				apb(1'b0, hmcdaf_pkg::ADDR_CMD, 32'h0);
			end
			check(rd, {1'b0, j[2], 22'h0, 8'(j % 4)});
			apb(1'b0, hmcdaf_pkg::ADDR_DATA, 32'h0);
			check(rd, j < 4 ? seed : shadow[j % 4]);
			if (j < 4) begin
				shadow[j] = seed;
			end
		end
		$display("test indirect done");
		// full duplex: high 10h, low 08h, any-frame enable
		apb(1'b1, hmcdaf_pkg::ADDR_AFC, 32'h00100801);
		pauseTimeField <= seed[31:16];
		macMode <= 4'b1110;
		quiet(8);
		macMode <= 4'b0110;
		rxDataUsed <= 16'h0400;
		quiet(8);
		macMode <= 4'b1110;
		pause(seed[31:16]);
		quiet(10);
		rxDataUsed <= 16'h0200;
		quiet(8);
		rxDataUsed <= 16'h01ff;
		pause(16'h0);
		rxDataUsed <= 16'h0;
		quiet(8);
		$display("test pause done");
		// half duplex jam per duration code, both speeds
		for (int m = 0; m < 4; m++) begin
			seed = lfsr(seed);
			apb(1'b1, hmcdaf_pkg::ADDR_AFC, {16'h0010, 8'h08, codes[m], ens[m]});
			macMode <= {2'b10, seed[0], 1'b0};
			rxDataUsed <= 16'h0400;
			jam(hits[(m + 1) % 4], 0);
			jam(hits[m], jamLen(int'(codes[m]), seed[0]));
		end
		apb(1'b1, hmcdaf_pkg::ADDR_AFC, 32'h00100811);
		jam(4'b1000, jamLen(1, seed[0]));
		macMode <= 4'b1110;
		jam(4'b1111, 0);
		$display("test jam done");
		// hardwired flow control keeps hysteresis between the levels
		macMode <= 4'b1111;
		repeat (3) @(posedge core_clk);
		check({31'h0, hwFcAssert}, 32'h1);
		// status shows the level in 64-byte units and the hardwired flag
		apb(1'b0, hmcdaf_pkg::ADDR_STAT, 32'h0);
		check(32'({rd[25:16], rd[2]}), 32'h21);
		rxDataUsed <= 16'h0300;
		repeat (3) @(posedge core_clk);
		check({31'h0, hwFcAssert}, 32'h1);
		rxDataUsed <= 16'h01c0;
		repeat (3) @(posedge core_clk);
		check({31'h0, hwFcAssert}, 32'h0);
		$display("test hardwired done");
		summarize();
	end
endmodule
